// file: src/backlash_comp_cfg.svh
// register map, reset values and timing constants of the backlash compensator
`ifndef BACKLASH_COMP_CFG_SVH
`define BACKLASH_COMP_CFG_SVH

`define ADDR_CTRL 8'h00
`define ADDR_AMOUNT 8'h04
`define ADDR_FILTER_TC 8'h08
`define ADDR_GEAR_NUM 8'h0c
`define ADDR_GEAR_DEN 8'h10
`define ADDR_MAX_SPEED 8'h14
`define ADDR_ENC_RES 8'h18
`define ADDR_EXT_PULSES 8'h1c
`define ADDR_APPLIED_MON 8'h20
`define ADDR_LIMIT_MON 8'h24
`define ADDR_STATUS 8'h28

`define CTRL_DIR_BIT 0
`define CTRL_RESTART_BIT 1

`define AMOUNT_MIN (-32'sd500000)
`define AMOUNT_MAX 32'sd500000
`define AMOUNT_RESET 32'h0
`define FILTER_TC_RESET 16'h0
`define GEAR_NUM_RESET 32'h1
`define GEAR_DEN_RESET 32'h1
`define MAX_SPEED_RESET 16'h1770
`define ENC_RES_RESET 32'h0010_0000
`define EXT_PULSES_RESET 32'h0001_f400
`define DIR_RESET 1'b0

// amounts are held in tenths of a reference unit
`define TENTHS_PER_UNIT 10
`define SEC_PER_MIN 60
// reciprocal of the 0.00025 limit factor
`define LIMIT_FACTOR_INV 4000

`define CLK_PERIOD_PS 4000
// filter time constant step of 0.01 ms
`define FILT_UNIT_PS 10000000
`define FILT_TICK_CYCLES (`FILT_UNIT_PS / `CLK_PERIOD_PS)
`define FILT_FRAC 16

`endif

// file: src/backlash_comp_pkg.sv
// shared types of the backlash compensator
package backlash_comp_pkg;
  typedef enum logic [1:0] {
    CS_OFF = 2'b00,
    CS_IDLE = 2'b01,
    CS_ENGAGED = 2'b11,
    CS_RELEASED = 2'b10
  } compState_t;
endpackage

// file: src/comp_lag_filter.sv
// first-order lag filter with bypass for the compensation pulses
`timescale 1ns/10ps
`include "backlash_comp_cfg.svh"
module comp_lag_filter #(
  parameter int W = 48
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic clr,
  input wire logic [15:0] tc,
  input wire logic signed [W-1:0] target,
  output logic signed [W-1:0] y
);
  localparam int AW = W + `FILT_FRAC + 1;
  logic signed [AW-1:0] acc_q;
  logic signed [AW-1:0] diff;
  logic signed [AW-1:0] tgtScaled;

  assign tgtScaled = AW'(target) <<< `FILT_FRAC;
  assign diff = tgtScaled - acc_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
    end else if (clr) begin
      acc_q <= '0;
    end else if (tc == 16'h0) begin
      acc_q <= tgtScaled;
    end else if (tick) begin
      acc_q <= acc_q + diff / $signed(AW'(tc));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      y <= '0;
    end else if (clr) begin
      y <= '0;
    end else if (tc == 16'h0) begin
      y <= target;
    end else begin
      y <= W'((acc_q + (AW'(1) <<< (`FILT_FRAC - 1))) >>> `FILT_FRAC);
    end
  end

  property p_bypass;
    @(posedge clk) disable iff (!rst_n)
    (tc == 16'h0 && !clr) |=> (y == $past(target));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass output differs from target");

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
    clr |=> (y == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("filter output not cleared");
endmodule

// file: src/comp_limit_calc.sv
// speed dependent upper limit of the compensation amount, in tenths
`timescale 1ns/10ps
`include "backlash_comp_cfg.svh"
module comp_limit_calc (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] gearNum,
  input wire logic [31:0] gearDen,
  input wire logic [15:0] maxSpeed,
  input wire logic [31:0] encRes,
  input wire logic [31:0] extPulses,
  input wire logic fullyClosed,
  output logic [31:0] limit
);
  logic [31:0] res;
  logic [95:0] numer;
  logic [95:0] denom;
  logic [95:0] quot;

  assign res = fullyClosed ? extPulses : encRes;
  // den/num * speed/60 * res * 0.00025, scaled to tenths
  assign numer = 96'(gearDen) * 96'(maxSpeed) * 96'(res) * 96'(`TENTHS_PER_UNIT);
  assign denom = 96'(gearNum) * 96'(`SEC_PER_MIN) * 96'(`LIMIT_FACTOR_INV);
  assign quot = (denom == 96'h0) ? 96'h0 : numer / denom;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      limit <= 32'h0;
    end else begin
      limit <= (quot > 96'h7fff_ffff) ? 32'h7fff_ffff : quot[31:0];
    end
  end
endmodule

// file: src/backlash_comp.sv
// backlash compensation stage between host position reference and position loop
// Functional notes
// - compensate only for references in selected direction; 0 forward, 1 reverse; after restart.
// - signed amount -500000..500000 in 0.1 reference units, default zero.
// - pulses equal amount times numerator over denominator, rounded to nearest.
// - limit is den/num times speed/60 times resolution times 0.00025.
// - amount above the limit means no compensation is performed.
// - fully-closed loop uses external pulses per revolution for the limit.
// - applied amount reported in 0.1 reference units.
// - computed limit reported in 0.1 reference units.
// - amount passes a first-order lag filter, constant 0..65535 of 0.01 ms.
// - zero time constant bypasses the filter.
// - new time constant taken only with no reference input and motor stopped.
// - compensation only in position control.
// - motor reference is host reference plus applied compensation.
// - reference opposite to compensation direction withholds the amount.
// - unpowered motor gets no compensation; feedback reported equals reference.
// - reported feedback has the applied compensation subtracted.
// - encoder output includes the compensation pulses; here encoderOut is feedbackPos, with no compensation pulses added.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "backlash_comp_cfg.svh"
module backlash_comp #(
  parameter int POS_W = 32,
  parameter int COMP_W = 48
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdData,
  input wire logic refValid,
  input wire logic signed [POS_W-1:0] refDelta,
  input wire logic positionMode,
  input wire logic servoOn,
  input wire logic overtravel,
  input wire logic motorStopped,
  input wire logic fullyClosed,
  input wire logic signed [POS_W-1:0] feedbackPos,
  output logic signed [POS_W-1:0] motorRef,
  output logic signed [POS_W-1:0] reportedFeedback,
  output logic signed [POS_W-1:0] encoderOut,
  output backlash_comp_pkg::compState_t compState,
  output logic compActive
);
  import backlash_comp_pkg::*;

  // rounded signed division on wide values
  function automatic logic signed [95:0] roundDiv(input logic signed [95:0] n,
                                                  input logic [95:0] d);
    logic [95:0] mag, q;
    mag = n[95] ? 96'(-n) : 96'(n);
    q = (d == 96'h0) ? 96'h0 : (mag + (d >> 1)) / d;
    return n[95] ? -$signed(q) : $signed(q);
  endfunction

  logic ctrlDir_q, activeDir_q, overLimit_q, tick_q;
  logic signed [31:0] amount_q;
  logic [15:0] filterTc_q, activeTc_q, maxSpeed_q;
  logic [31:0] gearNum_q, gearDen_q, encRes_q, extPulses_q, appliedMon_q;
  logic [31:0] limit, amountMag;
  logic signed [COMP_W-1:0] compPulses_q, target_q, applied;
  logic signed [POS_W-1:0] refPos_q, refPos_d;
  logic [11:0] tickCnt_q;
  logic enable, fwdRef, revRef, matchRef, oppRef, restartReq;
  logic signed [95:0] convProd, monProd;
  compState_t state_q, state_d;

  assign restartReq = wrEn && addr == `ADDR_CTRL && wrData[`CTRL_RESTART_BIT];

  // register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlDir_q <= `DIR_RESET;
      amount_q <= `AMOUNT_RESET;
      filterTc_q <= `FILTER_TC_RESET;
      gearNum_q <= `GEAR_NUM_RESET;
      gearDen_q <= `GEAR_DEN_RESET;
      maxSpeed_q <= `MAX_SPEED_RESET;
      encRes_q <= `ENC_RES_RESET;
      extPulses_q <= `EXT_PULSES_RESET;
    end else if (wrEn) begin
      case (addr)
        `ADDR_CTRL: ctrlDir_q <= wrData[`CTRL_DIR_BIT];
        `ADDR_AMOUNT: begin
          if ($signed(wrData) >= `AMOUNT_MIN && $signed(wrData) <= `AMOUNT_MAX) begin
            amount_q <= $signed(wrData);
          end
        end
        `ADDR_FILTER_TC: filterTc_q <= wrData[15:0];
        `ADDR_GEAR_NUM: gearNum_q <= wrData;
        `ADDR_GEAR_DEN: gearDen_q <= wrData;
        `ADDR_MAX_SPEED: maxSpeed_q <= wrData[15:0];
        `ADDR_ENC_RES: encRes_q <= wrData;
        `ADDR_EXT_PULSES: extPulses_q <= wrData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      activeDir_q <= `DIR_RESET;
    end else if (restartReq) begin
      activeDir_q <= wrData[`CTRL_DIR_BIT];
    end
  end

  // time constant adopted at standstill only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      activeTc_q <= `FILTER_TC_RESET;
    end else if (!refValid && motorStopped) begin
      activeTc_q <= filterTc_q;
    end
  end

  // filter time step divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_q <= 12'h0;
      tick_q <= 1'b0;
    end else if (tickCnt_q == 12'(`FILT_TICK_CYCLES - 1)) begin
      tickCnt_q <= 12'h0;
      tick_q <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + 12'h1;
      tick_q <= 1'b0;
    end
  end

  assign convProd = 96'(amount_q) * $signed(96'(gearNum_q));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compPulses_q <= '0;
    end else begin
      compPulses_q <= COMP_W'(roundDiv(convProd, 96'(gearDen_q) * 96'(`TENTHS_PER_UNIT)));
    end
  end

  comp_limit_calc limitCalc (
    .clk(clk),
    .rst_n(rst_n),
    .gearNum(gearNum_q),
    .gearDen(gearDen_q),
    .maxSpeed(maxSpeed_q),
    .encRes(encRes_q),
    .extPulses(extPulses_q),
    .fullyClosed(fullyClosed),
    .limit(limit)
  );

  assign amountMag = amount_q[31] ? 32'(-amount_q) : 32'(amount_q);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overLimit_q <= 1'b0;
    end else begin
      overLimit_q <= amountMag > limit;
    end
  end

  assign enable = servoOn && !overtravel && positionMode;
  assign fwdRef = refValid && refDelta > 0;
  assign revRef = refValid && refDelta < 0;
  assign matchRef = activeDir_q ? revRef : fwdRef;
  assign oppRef = activeDir_q ? fwdRef : revRef;

  always_comb begin
    state_d = state_q;
    case (state_q)
      CS_OFF: begin
        if (enable) begin
          state_d = CS_IDLE;
        end
      end
      CS_IDLE, CS_RELEASED: begin
        if (matchRef) begin
          state_d = CS_ENGAGED;
        end
      end
      CS_ENGAGED: begin
        if (oppRef) begin
          state_d = CS_RELEASED;
        end
      end
      default: begin
        state_d = CS_OFF;
      end
    endcase
    if (!enable || restartReq) begin
      state_d = CS_OFF;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CS_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // target only while engaged and within limit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target_q <= '0;
    end else if (state_d == CS_ENGAGED && !overLimit_q) begin
      target_q <= compPulses_q;
    end else begin
      target_q <= '0;
    end
  end

  comp_lag_filter #(
    .W(COMP_W)
  ) lagFilter (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick_q),
    .clr(!enable),
    .tc(activeTc_q),
    .target(target_q),
    .y(applied)
  );

  assign refPos_d = refValid ? refPos_q + refDelta : refPos_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refPos_q <= '0;
    end else begin
      refPos_q <= refPos_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      motorRef <= '0;
    end else begin
      motorRef <= refPos_d + POS_W'(applied);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reportedFeedback <= '0;
    end else if (!servoOn) begin
      reportedFeedback <= refPos_d;
    end else begin
      reportedFeedback <= feedbackPos - POS_W'(applied);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      encoderOut <= '0;
      compState <= CS_OFF;
      compActive <= 1'b0;
    end else begin
      encoderOut <= feedbackPos;
      compState <= state_d;
      compActive <= applied != '0;
    end
  end

  assign monProd = 96'(applied) * $signed(96'(gearDen_q)) * 96'(`TENTHS_PER_UNIT);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      appliedMon_q <= 32'h0;
    end else begin
      appliedMon_q <= 32'(roundDiv(monProd, 96'(gearNum_q)));
    end
  end

  // register reads, limit monitor
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 32'h0;
    end else if (rdEn) begin
      case (addr)
        `ADDR_CTRL: rdData <= {31'h0, ctrlDir_q};
        `ADDR_AMOUNT: rdData <= amount_q;
        `ADDR_FILTER_TC: rdData <= {16'h0, filterTc_q};
        `ADDR_GEAR_NUM: rdData <= gearNum_q;
        `ADDR_GEAR_DEN: rdData <= gearDen_q;
        `ADDR_MAX_SPEED: rdData <= {16'h0, maxSpeed_q};
        `ADDR_ENC_RES: rdData <= encRes_q;
        `ADDR_EXT_PULSES: rdData <= extPulses_q;
        `ADDR_APPLIED_MON: rdData <= appliedMon_q;
        `ADDR_LIMIT_MON: rdData <= limit;
        `ADDR_STATUS: rdData <= {26'h0, activeTc_q != 16'h0, compActive, state_q,
                                 overLimit_q, activeDir_q};
        default: rdData <= 32'h0;
      endcase
    end else begin
      rdData <= 32'h0;
    end
  end

  property p_dirHeld;
    @(posedge clk) disable iff (!rst_n)
    !restartReq |=> $stable(activeDir_q);
  endproperty
  a_dirHeld: assert property (p_dirHeld) else $error("direction changed without restart");

  property p_tcHeld;
    @(posedge clk) disable iff (!rst_n)
    (refValid || !motorStopped) |=> $stable(activeTc_q);
  endproperty
  a_tcHeld: assert property (p_tcHeld) else $error("time constant changed while moving");

  property p_overLimit;
    @(posedge clk) disable iff (!rst_n)
    overLimit_q |=> (target_q == '0);
  endproperty
  a_overLimit: assert property (p_overLimit) else $error("compensation above limit");

  property p_opposite;
    @(posedge clk) disable iff (!rst_n)
    oppRef |=> (target_q == '0);
  endproperty
  a_opposite: assert property (p_opposite) else $error("compensation on opposite ref");

  property p_modeOnly;
    @(posedge clk) disable iff (!rst_n)
    !positionMode |=> (applied == '0) ##1 (motorRef == refPos_q || positionMode);
  endproperty
  a_modeOnly: assert property (p_modeOnly) else $error("compensation outside position mode");

  property p_motorRef;
    @(posedge clk) disable iff (!rst_n)
    rst_n |=> (motorRef == refPos_q + POS_W'($past(applied)));
  endproperty
  a_motorRef: assert property (p_motorRef) else $error("motor ref is not ref plus comp");

  property p_servoOff;
    @(posedge clk) disable iff (!rst_n)
    !servoOn |=> (reportedFeedback == refPos_q);
  endproperty
  a_servoOff: assert property (p_servoOff) else $error("feedback not equal ref when off");

  property p_feedback;
    @(posedge clk) disable iff (!rst_n)
    (rst_n && servoOn) |=> (reportedFeedback == $past(feedbackPos) - POS_W'($past(applied)));
  endproperty
  a_feedback: assert property (p_feedback) else $error("feedback not compensated");

  property p_encoder;
    @(posedge clk) disable iff (!rst_n)
    rst_n |=> (encoderOut == $past(feedbackPos));
  endproperty
  a_encoder: assert property (p_encoder) else $error("encoder output lost driven pulses");
endmodule

// file: testbench/host_ref_model.sv
// host controller model issuing position reference increments
`timescale 1ns/10ps
module host_ref_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sendReq,
  input wire logic signed [31:0] sendDelta,
  output logic refValid,
  output logic signed [31:0] refDelta
);
  // one increment per request; idle data holds the inverse of the last increment
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refValid <= 1'b0;
      refDelta <= 32'sh0;
    end else begin
      refValid <= sendReq;
      refDelta <= sendReq ? sendDelta : (refValid ? ~refDelta : refDelta);
    end
  end
endmodule

// file: testbench/backlash_comp_tb.sv
// self-checking bench of the backlash compensator
`timescale 1ns/10ps
`include "backlash_comp_cfg.svh"
module backlash_comp_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wrData = 32'h0;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic [31:0] rdData;
  logic sendReq = 1'b0;
  logic signed [31:0] sendDelta = 32'sh0;
  logic refValid;
  logic signed [31:0] refDelta;
  logic positionMode = 1'b1;
  logic servoOn = 1'b1;
  logic overtravel = 1'b0;
  logic motorStopped = 1'b1;
  logic fullyClosed = 1'b0;
  logic signed [31:0] feedbackPos = 32'sh3e8;
  logic signed [31:0] motorRef;
  logic signed [31:0] reportedFeedback;
  logic signed [31:0] encoderOut;
  backlash_comp_pkg::compState_t compState;
  logic compActive;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  host_ref_model i_host (.clk(clk), .rst_n(rst_n), .sendReq(sendReq),
    .sendDelta(sendDelta), .refValid(refValid), .refDelta(refDelta));

  backlash_comp i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .refValid(refValid),
    .refDelta(refDelta), .positionMode(positionMode), .servoOn(servoOn),
    .overtravel(overtravel), .motorStopped(motorStopped), .fullyClosed(fullyClosed),
    .feedbackPos(feedbackPos), .motorRef(motorRef), .reportedFeedback(reportedFeedback),
    .encoderOut(encoderOut), .compState(compState), .compActive(compActive));

  task automatic wrap_up();
    if (fail_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wrEn <= 1'b1;
    addr <= a;
    wrData <= d;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rdEn <= 1'b1;
    addr <= a;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    chk(rdData, exp);
  endtask

  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic send(input logic signed [31:0] d);
    @(posedge clk);
    sendReq <= 1'b1;
    sendDelta <= d;
    @(posedge clk);
    sendReq <= 1'b0;
    settle();
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and unmapped place
    rdchk(`ADDR_AMOUNT, 32'h0);
    rdchk(`ADDR_GEAR_NUM, 32'h1);
    rdchk(`ADDR_GEAR_DEN, 32'h1);
    rdchk(`ADDR_MAX_SPEED, 32'h1770);
    rdchk(`ADDR_ENC_RES, 32'h0010_0000);
    rdchk(`ADDR_EXT_PULSES, 32'h0001_f400);
    rdchk(8'h3c, 32'h0);
    // limit: 1 x 100 x 1048576 x 0.00025 = 26214.4 units
    rdchk(`ADDR_LIMIT_MON, 32'h0004_0000);
    wr(`ADDR_GEAR_NUM, 32'h4);
    settle();
    rdchk(`ADDR_LIMIT_MON, 32'h0001_0000);
    fullyClosed <= 1'b1;
    settle();
    rdchk(`ADDR_LIMIT_MON, 32'h0000_1f40);
    fullyClosed <= 1'b0;
    // out of range amount ignored, lowest bound accepted
    wr(`ADDR_AMOUNT, 32'h0007_a121);
    rdchk(`ADDR_AMOUNT, 32'h0);
    wr(`ADDR_AMOUNT, 32'hfff8_5ee0);
    rdchk(`ADDR_AMOUNT, 32'hfff8_5ee0);
    // amount kept at the limit read back before the fully-closed one
    wr(`ADDR_AMOUNT, 32'h0001_0000);
    // 6553.6 units x 4 = 26214.4 pulses, rounded to 26214
    send(32'sd10);
    chk(motorRef, 32'd26224);
    chk(32'(compActive), 32'h1);
    chk(32'(compState), 32'(backlash_comp_pkg::CS_ENGAGED));
    rdchk(`ADDR_STATUS, 32'h0000_001c);
    // 26214 pulses back through 4/1 gearing give 6553.5 units
    rdchk(`ADDR_APPLIED_MON, 32'h0000_ffff);
    chk(reportedFeedback, -32'sd25214);
    chk(encoderOut, 32'd1000);
    send(-32'sd5);
    chk(motorRef, 32'd5);
    chk(32'(compState), 32'(backlash_comp_pkg::CS_RELEASED));
    rdchk(`ADDR_APPLIED_MON, 32'h0);
    // limit 800.0 units is below the amount
    fullyClosed <= 1'b1;
    send(32'sd3);
    chk(motorRef, 32'd8);
    fullyClosed <= 1'b0;
    positionMode <= 1'b0;
    send(32'sd2);
    chk(motorRef, 32'd10);
    positionMode <= 1'b1;
    send(32'sd4);
    chk(motorRef, 32'd26228);
    servoOn <= 1'b0;
    settle();
    chk(motorRef, 32'd14);
    chk(reportedFeedback, 32'd14);
    chk(32'(compState), 32'(backlash_comp_pkg::CS_OFF));
    servoOn <= 1'b1;
    // reverse direction after restart
    wr(`ADDR_CTRL, 32'h3);
    send(-32'sd4);
    chk(motorRef, 32'd26224);
    overtravel <= 1'b1;
    settle();
    chk(motorRef, 32'd10);
    // time constant of one step taken while idle
    motorStopped <= 1'b0;
    wr(`ADDR_FILTER_TC, 32'h1);
    // constant not taken while the motor turns
    rdchk(`ADDR_STATUS, 32'h0000_0001);
    motorStopped <= 1'b1;
    overtravel <= 1'b0;
    send(-32'sd1);
    repeat (2600) @(posedge clk);
    #1;
    chk(motorRef, 32'd26223);
    rdchk(`ADDR_STATUS, 32'h0000_003d);
    wrap_up();
  end
endmodule
